//--- hw/vpic_pkg.sv
// constants, carrier types and state layout of the vectored priority interrupt controller
// Summary of operation
// - seventeen registers: two global controls, flag, enable, priority groups, pending register
// - uart error request is vector 73, request 65, address 0x96 or 0x196
// - traps fixed at vectors 1 to 4, alternate table adds 0x100
// - first global control holds nesting disable and trap status flags
// - second global control holds external edge polarity and alternate table select
// - hardware sets a source flag on request; only software clears it
// - a source requests service only while its enable bit is set
// - each user source has a three bit priority, one of eight levels
// - pending vector number latched in 7 bits, new level in 4 bits
// - the latched new level equals the priority of the pending interrupt
// - flag, enable and priority bits follow request number order from bit 0
// - low three cpu level bits sit at status word bits 7 to 5, writable
// - the top cpu level bit is read-only to software
// - low bits 111 mean level 7 and block all user interrupts
// - cpu level is the top bit over the three low bits, 0 to 15
// - all user interrupts blocked while the top cpu level bit is one
// - with nesting disabled the low cpu level bits ignore software writes
// - nesting disable set prevents nesting; clear permits it
// - alternate table select one uses the alternate table, zero the standard one
// - polarity bit one detects the falling edge, zero the rising edge
package vpic_pkg;

	localparam int VPIC_NSRC = 80;
	localparam int VPIC_NEXT = 3;

	// register indices on the plain register port
	localparam logic [4:0] VPIC_REG_CTL1   = 5'h00;
	localparam logic [4:0] VPIC_REG_CTL2   = 5'h01;
	localparam logic [4:0] VPIC_REG_FLAG0  = 5'h02;
	localparam logic [4:0] VPIC_REG_EN0    = 5'h05;
	localparam logic [4:0] VPIC_REG_PRIO0  = 5'h08;
	localparam logic [4:0] VPIC_REG_PEND   = 5'h10;
	localparam logic [4:0] VPIC_REG_STATUS = 5'h11;
	localparam logic [4:0] VPIC_REG_CORE   = 5'h12;
	localparam int         VPIC_NBANK      = 3;
	localparam int         VPIC_NPRIO      = 8;

	// source bank of each flag/enable register, priority group of each priority register
	localparam logic [2:0][2:0] VPIC_BANK_MAP = {3'h4, 3'h1, 3'h0};
	localparam logic [7:0][4:0] VPIC_PGRP_MAP =
		{5'h10, 5'h07, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

	// field positions
	localparam int VPIC_NEST_BIT  = 15;
	localparam int VPIC_DIV0_BIT  = 6;
	localparam int VPIC_MATH_BIT  = 4;
	localparam int VPIC_ADDR_BIT  = 3;
	localparam int VPIC_STK_BIT   = 2;
	localparam int VPIC_OSC_BIT   = 1;
	localparam int VPIC_ALT_BIT   = 15;
	localparam int VPIC_IPL_LSB   = 5;
	localparam int VPIC_DC_BIT    = 8;
	localparam int VPIC_CPU_PRIORITY_TOP_BIT_BIT  = 3;
	localparam int VPIC_PSV_BIT   = 2;

	// vectors, tables and levels
	localparam logic [6:0]  VPIC_USER_VEC0     = 7'h08;
	localparam logic [6:0]  VPIC_VEC_OSC       = 7'h01;
	localparam logic [6:0]  VPIC_VEC_MATH      = 7'h04;
	localparam logic [6:0]  VPIC_UART_ERR_VEC  = 7'h49;
	localparam int          VPIC_UART_ERR_IRQ  = 65;
	localparam logic [23:0] VPIC_UART_ERR_ADDR = 24'h000096;
	localparam logic [23:0] VPIC_UART_ERR_ALT  = 24'h000196;
	localparam logic [23:0] VPIC_TABLE_BASE    = 24'h000004;
	localparam logic [23:0] VPIC_ALT_OFFSET    = 24'h000100;
	localparam logic [3:0]  VPIC_LEVEL_NONEST  = 4'h7;
	localparam logic [3:0][3:0] VPIC_TRAP_LEVEL = {4'hc, 4'hd, 4'he, 4'hf};
	localparam logic [2:0][6:0] VPIC_EXT_SRC    = {7'h1d, 7'h14, 7'h00};
	localparam logic [3:0]  VPIC_IPL_RST       = 4'h0;

	typedef struct packed {
		logic div0;
		logic math;
		logic stack;
		logic addr;
		logic osc;
	} vpic_trap_t;

	typedef struct packed {
		logic                        nest_dis;
		vpic_trap_t                  trap_stat;
		logic [3:0]                  trap_pend;
		logic                        alt_sel;
		logic [VPIC_NEXT-1:0]        ext_pol;
		logic [VPIC_NEXT-1:0]        ext_prev;
		logic [VPIC_NSRC-1:0]        flags;
		logic [VPIC_NSRC-1:0]        en;
		logic [VPIC_NSRC-1:0][2:0]   prio;
		logic [3:0]                  cpu_priority_level;
		logic                        sr_dc;
		logic [3:0]                  sr_alu;
		logic                        psv;
		logic                        req;
		logic [6:0]                  pend_vec;
		logic [3:0]                  pend_lvl;
		logic [23:0]                 vaddr;
		logic [15:0]                 rdata;
	} vpic_state_t;

endpackage

//--- hw/vpic_ctrl.sv
// vectored priority interrupt and trap controller with register port
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module vpic_ctrl import vpic_pkg::*; #(
	parameter int NUM_SRC = VPIC_NSRC,
	parameter int NUM_EXT = VPIC_NEXT
) (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	// register port
	input  wire logic [4:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [15:0]          reg_rdata,
	// request sources
	input  wire logic [NUM_SRC-1:0]   periph_req,
	input  wire logic [NUM_EXT-1:0]   ext_pin,
	input  wire vpic_trap_t           trap_req,
	// processor core
	input  wire logic                 cpu_ack,
	input  wire logic                 cpu_ret,
	input  wire logic [3:0]           cpu_ret_level,
	output logic                      irq_req,
	output logic      [6:0]           irq_vector,
	output logic      [3:0]           irq_level,
	output logic      [23:0]          vector_addr,
	output logic      [3:0]           cpu_level
);

	if (NUM_SRC != VPIC_NSRC || NUM_EXT != VPIC_NEXT) begin : g_bad_size
		$error("vpic_ctrl: source counts must match the register layout");
	end

	vpic_state_t s;
	vpic_state_t n;

	// a source exists only if both its flag bank and its priority group are mapped
	function automatic logic src_mapped(input int idx);
		logic hit_b;
		logic hit_p;
		hit_b = 1'b0;
		hit_p = 1'b0;
		for (int b = 0; b < VPIC_NBANK; b++) begin
			if (int'(VPIC_BANK_MAP[b]) == idx / 16) begin
				hit_b = 1'b1;
			end
		end
		for (int p = 0; p < VPIC_NPRIO; p++) begin
			if (int'(VPIC_PGRP_MAP[p]) == idx / 4) begin
				hit_p = 1'b1;
			end
		end
		return hit_b & hit_p;
	endfunction

	always_comb begin
		logic [NUM_SRC-1:0] req;
		logic [3:0]         best;
		logic [6:0]         bvec;
		logic               found;
		logic               pin_edge;
		logic [15:0]        rd;
		int                 base;
		req      = periph_req;
		best     = 4'h0;
		bvec     = 7'h00;
		found    = 1'b0;
		pin_edge = 1'b0;
		rd       = 16'h0000;
		base     = 0;
		n        = s;

		// external pins: polarity picks which edge counts
		for (int e = 0; e < NUM_EXT; e++) begin
			pin_edge = s.ext_pol[e] ? (s.ext_prev[e] & ~ext_pin[e])
			                        : (~s.ext_prev[e] & ext_pin[e]);
			req[VPIC_EXT_SRC[e]] = req[VPIC_EXT_SRC[e]] | pin_edge;
		end
		n.ext_prev = ext_pin;

		// software writes
		if (reg_wr) begin
			if (reg_addr == VPIC_REG_CTL1) begin
				n.nest_dis        = reg_wdata[VPIC_NEST_BIT];
				n.trap_stat.div0  = reg_wdata[VPIC_DIV0_BIT];
				n.trap_stat.math  = reg_wdata[VPIC_MATH_BIT];
				n.trap_stat.addr  = reg_wdata[VPIC_ADDR_BIT];
				n.trap_stat.stack = reg_wdata[VPIC_STK_BIT];
				n.trap_stat.osc   = reg_wdata[VPIC_OSC_BIT];
			end
			if (reg_addr == VPIC_REG_CTL2) begin
				n.alt_sel = reg_wdata[VPIC_ALT_BIT];
				n.ext_pol = reg_wdata[NUM_EXT-1:0];
			end
			for (int b = 0; b < VPIC_NBANK; b++) begin
				base = int'(VPIC_BANK_MAP[b]) * 16;
				for (int i = 0; i < 16; i++) begin
					if (src_mapped(base + i)) begin
						if (reg_addr == VPIC_REG_FLAG0 + 5'(b)) begin
							n.flags[base + i] = reg_wdata[i];
						end
						if (reg_addr == VPIC_REG_EN0 + 5'(b)) begin
							n.en[base + i] = reg_wdata[i];
						end
					end
				end
			end
			for (int p = 0; p < VPIC_NPRIO; p++) begin
				base = int'(VPIC_PGRP_MAP[p]) * 4;
				for (int i = 0; i < 4; i++) begin
					if (reg_addr == VPIC_REG_PRIO0 + 5'(p) && src_mapped(base + i)) begin
						n.prio[base + i] = reg_wdata[4*i +: 3];
					end
				end
			end
			if (reg_addr == VPIC_REG_STATUS) begin
				n.sr_dc  = reg_wdata[VPIC_DC_BIT];
				n.sr_alu = reg_wdata[3:0];
				if (!s.nest_dis) begin
					n.cpu_priority_level[2:0] = reg_wdata[VPIC_IPL_LSB +: 3];
				end
			end
			if (reg_addr == VPIC_REG_CORE) begin
				// top level bit is deliberately not taken from the write
				n.psv = reg_wdata[VPIC_PSV_BIT];
			end
		end

		// hardware sets after the software write so a same-cycle request is kept
		for (int i = 0; i < NUM_SRC; i++) begin
			if (src_mapped(i) && req[i]) begin
				n.flags[i] = 1'b1;
			end
		end
		n.trap_stat = n.trap_stat | trap_req;

		// core returns and acknowledges steer the cpu level
		if (cpu_ret) begin
			n.cpu_priority_level = cpu_ret_level;
		end
		if (cpu_ack && s.req) begin
			if (s.pend_vec < VPIC_USER_VEC0) begin
				n.trap_pend[2'(s.pend_vec - VPIC_VEC_OSC)] = 1'b0;
				n.cpu_priority_level = s.pend_lvl;
			end else begin
				// without nesting a user handler runs at level 7 so no user source preempts it
				n.cpu_priority_level = s.nest_dis ? VPIC_LEVEL_NONEST : s.pend_lvl;
			end
		end

		// set after the ack so a trap raised while its last instance is acked is kept
		n.trap_pend = n.trap_pend | {trap_req.math | trap_req.div0, trap_req.stack,
		                             trap_req.addr, trap_req.osc};

		// arbitration; strict compare keeps the lowest request on a tie
		best = n.cpu_priority_level;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (src_mapped(i) && n.flags[i] && n.en[i] && !n.cpu_priority_level[3]
			    && {1'b0, n.prio[i]} > best) begin
				best  = {1'b0, n.prio[i]};
				bvec  = 7'(i) + VPIC_USER_VEC0;
				found = 1'b1;
			end
		end
		for (int t = 3; t >= 0; t--) begin
			if (n.trap_pend[t]) begin
				best  = VPIC_TRAP_LEVEL[t];
				bvec  = VPIC_VEC_OSC + 7'(t);
				found = 1'b1;
			end
		end
		n.req = found;
		if (found) begin
			n.pend_vec = bvec;
			n.pend_lvl = best;
			n.vaddr    = (n.alt_sel ? VPIC_ALT_OFFSET : 24'h000000) + VPIC_TABLE_BASE
			             + {16'h0000, bvec, 1'b0};
		end

		// read mux; unmapped indices read zero
		if (reg_addr == VPIC_REG_CTL1) begin
			rd[VPIC_NEST_BIT] = s.nest_dis;
			rd[VPIC_DIV0_BIT] = s.trap_stat.div0;
			rd[VPIC_MATH_BIT] = s.trap_stat.math;
			rd[VPIC_ADDR_BIT] = s.trap_stat.addr;
			rd[VPIC_STK_BIT]  = s.trap_stat.stack;
			rd[VPIC_OSC_BIT]  = s.trap_stat.osc;
		end
		if (reg_addr == VPIC_REG_CTL2) begin
			rd[VPIC_ALT_BIT]    = s.alt_sel;
			rd[NUM_EXT-1:0]     = s.ext_pol;
		end
		for (int b = 0; b < VPIC_NBANK; b++) begin
			base = int'(VPIC_BANK_MAP[b]) * 16;
			if (reg_addr == VPIC_REG_FLAG0 + 5'(b)) begin
				rd = s.flags[base +: 16];
			end
			if (reg_addr == VPIC_REG_EN0 + 5'(b)) begin
				rd = s.en[base +: 16];
			end
		end
		for (int p = 0; p < VPIC_NPRIO; p++) begin
			base = int'(VPIC_PGRP_MAP[p]) * 4;
			if (reg_addr == VPIC_REG_PRIO0 + 5'(p)) begin
				for (int i = 0; i < 4; i++) begin
					rd[4*i +: 3] = s.prio[base + i];
				end
			end
		end
		if (reg_addr == VPIC_REG_PEND) begin
			rd = {4'h0, s.pend_lvl, 1'b0, s.pend_vec};
		end
		if (reg_addr == VPIC_REG_STATUS) begin
			rd = {7'h00, s.sr_dc, s.cpu_priority_level[2:0], 1'b0, s.sr_alu};
		end
		if (reg_addr == VPIC_REG_CORE) begin
			rd[VPIC_CPU_PRIORITY_TOP_BIT_BIT] = s.cpu_priority_level[3];
			rd[VPIC_PSV_BIT]  = s.psv;
		end
		n.rdata = reg_rd ? rd : 16'h0000;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s     <= '0;
			s.cpu_priority_level <= VPIC_IPL_RST;
		end else begin
			s <= n;
		end
	end

	assign reg_rdata   = s.rdata;
	assign irq_req     = s.req;
	assign irq_vector  = s.pend_vec;
	assign irq_level   = s.pend_lvl;
	assign vector_addr = s.vaddr;
	assign cpu_level   = s.cpu_priority_level;

	// assertion helpers
	logic [6:0] user_idx;
	logic       user_taken;
	assign user_idx   = irq_vector - VPIC_USER_VEC0;
	assign user_taken = irq_req && irq_vector >= VPIC_USER_VEC0;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_vec_addr;
		irq_req |-> vector_addr == (s.alt_sel ? VPIC_ALT_OFFSET : 24'h000000)
		            + VPIC_TABLE_BASE + {16'h0000, irq_vector, 1'b0};
	endproperty
	a_vec_addr: assert property (p_vec_addr) else $error("vector address mismatch");

	property p_uart_addr;
		irq_req && irq_vector == VPIC_UART_ERR_VEC
		|-> vector_addr == (s.alt_sel ? VPIC_UART_ERR_ALT : VPIC_UART_ERR_ADDR);
	endproperty
	a_uart_addr: assert property (p_uart_addr) else $error("uart error address wrong");

	property p_osc_trap;
		trap_req.osc |=> irq_req && irq_vector == VPIC_VEC_OSC && s.trap_stat.osc;
	endproperty
	a_osc_trap: assert property (p_osc_trap) else $error("oscillator trap not presented");

	property p_enabled;
		user_taken |-> s.en[user_idx] && s.flags[user_idx];
	endproperty
	a_enabled: assert property (p_enabled) else $error("disabled source presented");

	property p_level;
		user_taken |-> irq_level == {1'b0, s.prio[user_idx]} && irq_level > cpu_level
		               && !cpu_level[3];
	endproperty
	a_level: assert property (p_level) else $error("user level not above cpu level");

	property p_nest_lock;
		s.nest_dis && reg_wr && reg_addr == VPIC_REG_STATUS && !cpu_ack && !cpu_ret
		|=> cpu_level == $past(cpu_level);
	endproperty
	a_nest_lock: assert property (p_nest_lock) else $error("level written while locked");

	property p_top_ro;
		reg_wr && reg_addr == VPIC_REG_CORE && !cpu_ack && !cpu_ret
		|=> cpu_level[3] == $past(cpu_level[3]);
	endproperty
	a_top_ro: assert property (p_top_ro) else $error("top level bit written");

	property p_flag_clear;
		$fell(s.flags[0]) |-> $past(reg_wr) && $past(reg_addr) == VPIC_REG_FLAG0;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag cleared by hardware");

	property p_pend_read;
		reg_rd && reg_addr == VPIC_REG_PEND
		|=> reg_rdata == {4'h0, $past(irq_level), 1'b0, $past(irq_vector)};
	endproperty
	a_pend_read: assert property (p_pend_read) else $error("pending register readback");

	property p_ext_rise;
		!s.ext_pol[0] && !s.ext_prev[0] && ext_pin[0] |=> s.flags[0];
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("rising edge missed");

endmodule

//--- testbench/vpic_core_model.sv
// behavioural processor core that takes presented vectors and returns from handlers
`timescale 1ns/1ps
module vpic_core_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// bench control
	input  wire logic       ack_en,
	input  wire logic [1:0] ack_slow,
	input  wire logic       ret_go,
	input  wire logic [3:0] ret_lvl,
	// controller side
	input  wire logic       irq_req,
	output logic            cpu_ack,
	output logic            cpu_ret,
	output logic [3:0]      cpu_ret_level
);
	logic [1:0] wait_r;

	// ack only while a vector stands; skip the cycle after an ack while the request drops
	always_ff @(posedge clk_sys) begin
		cpu_ack <= 1'b0;
		cpu_ret <= ret_go;
		cpu_ret_level <= ret_lvl;
		if (sys_rst) begin
			wait_r <= 2'h0;
		end else if (ack_en && irq_req && !cpu_ack) begin
			wait_r <= (wait_r == ack_slow) ? 2'h0 : wait_r + 2'h1;
			cpu_ack <= (wait_r == ack_slow);
		end
	end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the vectored priority interrupt controller
`timescale 1ns/1ps
module tb_top;
	import vpic_pkg::*;
	logic        clk_sys, sys_rst, reg_wr, reg_rd, cpu_ack, cpu_ret, irq_req;
	logic        ack_en, ret_go;
	logic [1:0]  ack_slow;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [79:0] periph_req;
	logic [2:0]  ext_pin;
	vpic_trap_t  trap_req;
	logic [3:0]  cpu_ret_level, ret_lvl, irq_level, cpu_level;
	logic [6:0]  irq_vector;
	logic [23:0] vector_addr;
	int          n_errors, n_tests;

	vpic_ctrl vpic_ctrl_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .periph_req, .ext_pin, .trap_req, .cpu_ack, .cpu_ret, .cpu_ret_level,
		.irq_req, .irq_vector, .irq_level, .vector_addr, .cpu_level);
	vpic_core_model vpic_core_model_i (.clk_sys, .sys_rst, .ack_en, .ack_slow, .ret_go,
		.ret_lvl, .irq_req, .cpu_ack, .cpu_ret, .cpu_ret_level);

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(nm, 24'(exp), 24'(reg_rdata));
	endtask

	task automatic preq(input int n);
		@(posedge clk_sys);
		periph_req[n] <= 1'b1;
		@(posedge clk_sys);
		periph_req[n] <= 1'b0;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask

	task automatic irq(input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
		settle();
		chk("irq_req", 24'h1, 24'(irq_req));
		chk("irq_vector", 24'(v), 24'(irq_vector));
		chk("irq_level", 24'(l), 24'(irq_level));
		chk("vector_addr", a, vector_addr);
	endtask

	task automatic take(input logic [3:0] lvl, input logic [1:0] s);
		@(posedge clk_sys);
		ack_en <= 1'b1;
		ack_slow <= s;
		// look off the edge so the level launched there has settled
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			#1;
			if (cpu_level === lvl) begin
				break;
			end
		end
		chk("cpu_level", 24'(lvl), 24'(cpu_level));
		@(posedge clk_sys);
		ack_en <= 1'b0;
		#1;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// the sequence needs a few hundred cycles at most
	initial begin
		#500000;
		n_errors++;
		results();
	end

	initial begin
		{sys_rst, reg_wr, reg_rd, ack_en, ret_go} = 5'h10;
		{reg_addr, reg_wdata, periph_req, ext_pin, trap_req} = '0;
		{ack_slow, ret_lvl} = '0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(VPIC_REG_CTL1, 16'h0000, "ctl1 reset");
		rd(VPIC_REG_PEND, 16'h0000, "pending reset");
		wr(5'h13, 16'hffff);
		rd(5'h13, 16'h0000, "unmapped");
		wr(VPIC_REG_PRIO0, 16'h5050);
		preq(1);
		preq(3);
		settle();
		chk("irq_req disabled", 24'h0, 24'(irq_req));
		wr(VPIC_REG_EN0, 16'h000a);
		irq(7'h09, 4'h5, 24'h000016);
		rd(VPIC_REG_PEND, 16'h0509, "pending");
		wr(VPIC_REG_PRIO0, 16'h6050);
		irq(7'h0b, 4'h6, 24'h00001a);
		take(4'h6, 2'h2);
		chk("irq_req lower pending", 24'h0, 24'(irq_req));
		rd(VPIC_REG_FLAG0, 16'h000a, "flags kept");
		wr(VPIC_REG_FLAG0, 16'h0000);
		rd(VPIC_REG_FLAG0, 16'h0000, "flags cleared");
		wr(VPIC_REG_STATUS, 16'h0060);
		rd(VPIC_REG_STATUS, 16'h0060, "status level");
		chk("cpu_level written", 24'h3, 24'(cpu_level));
		wr(VPIC_REG_CORE, 16'h000c);
		rd(VPIC_REG_CORE, 16'h0004, "top level bit");
		wr(VPIC_REG_CTL1, 16'h8000);
		wr(VPIC_REG_STATUS, 16'h00e0);
		rd(VPIC_REG_STATUS, 16'h0060, "status locked");
		preq(3);
		irq(7'h0b, 4'h6, 24'h00001a);
		take(4'h7, 2'h0);
		wr(VPIC_REG_CTL1, 16'h0000);
		wr(VPIC_REG_FLAG0, 16'h0000);
		wr(VPIC_REG_PRIO0, 16'h7050);
		preq(3);
		settle();
		chk("irq_req at level 7", 24'h0, 24'(irq_req));
		wr(VPIC_REG_STATUS, 16'h0000);
		irq(7'h0b, 4'h7, 24'h00001a);
		wr(VPIC_REG_FLAG0, 16'h0000);
		wr(VPIC_REG_CTL2, 16'h8000);
		wr(5'h07, 16'h0002);
		wr(5'h0f, 16'h0020);
		preq(65);
		irq(7'h49, 4'h2, 24'h000196);
		wr(VPIC_REG_CTL2, 16'h0000);
		irq(7'h49, 4'h2, 24'h000096);
		// user request stays pending through each of the four trap vectors
		for (int k = 0; k < 4; k++) begin
			wr(VPIC_REG_CTL2, {k[0], 15'h0000});
			@(posedge clk_sys);
			trap_req <= vpic_trap_t'(5'h01 << k);
			@(posedge clk_sys);
			trap_req <= '0;
			irq(7'(k + 1), 4'(15 - k), 24'(4 + 2 * (k + 1) + 256 * k[0]));
			take(4'(15 - k), 2'(k));
			chk("irq_req at trap level", 24'h0, 24'(irq_req));
			@(posedge clk_sys);
			ret_go  <= 1'b1;
			ret_lvl <= 4'h1;
			@(posedge clk_sys);
			ret_go <= 1'b0;
			settle();
			chk("cpu_level after return", 24'h1, 24'(cpu_level));
			chk("irq_req after return", 24'h1, 24'(irq_req));
		end
		rd(VPIC_REG_CTL1, 16'h001e, "trap status");
		@(posedge clk_sys);
		ext_pin <= 3'h3;
		settle();
		rd(VPIC_REG_FLAG0, 16'h0001, "pin zero rising");
		rd(VPIC_REG_FLAG0 + 5'h01, 16'h0010, "pin one rising");
		@(posedge clk_sys);
		ext_pin <= 3'h0;
		wr(VPIC_REG_FLAG0, 16'h0000);
		wr(VPIC_REG_CTL2, 16'h0001);
		@(posedge clk_sys);
		ext_pin <= 3'h1;
		rd(VPIC_REG_FLAG0, 16'h0000, "rising ignored");
		@(posedge clk_sys);
		ext_pin <= 3'h0;
		settle();
		rd(VPIC_REG_FLAG0, 16'h0001, "falling taken");
		// a reset in mid-run must clear flags, trap status and the level
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(VPIC_REG_CTL1, 16'h0000, "ctl1 after reset");
		rd(VPIC_REG_FLAG0, 16'h0000, "flags after reset");
		chk("cpu_level after reset", 24'h0, 24'(cpu_level));
		results();
	end
endmodule
